// ===== rtl/guard_lock_pkg.sv
// Shared constants, types and time-select functions for the guard lock block
package guard_lock_pkg;

	// ------------------------------------------------------------------
	// Timing base
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 10_000_000; // System clock rate
	localparam int unsigned TICK_MS     = 10;         // Timing tick period
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int          TICK_W      = 17;         // Holds TICK_CYCLES
	localparam int          CNT_W       = 12;         // Holds 2500 ticks

	// ------------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_UNL_SEL  = 8'h04;
	localparam logic [7:0] OFF_FBK_SEL  = 8'h08;
	localparam logic [7:0] OFF_STATE    = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STS  = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

	// Control bit positions
	localparam int CTRL_NO_GATE = 0; // Gate sensor not fitted
	localparam int CTRL_MAND    = 1; // Gate must open each cycle
	localparam int CTRL_SPRING  = 2; // Spring interlock lock
	localparam int CTRL_MONITOR = 3; // Monitored fault reset
	localparam int CTRL_ERR_EN  = 4; // Error output enabled
	localparam int CTRL_W       = 5;

	// Reset values
	localparam logic [4:0] CTRL_RST    = 5'h00;
	localparam logic [4:0] UNL_SEL_RST = 5'h05; // 0.5 s
	localparam logic [4:0] FBK_SEL_RST = 5'h09; // 100 ms
	localparam logic [2:0] IRQ_RST     = 3'h0;

	// Interrupt bit positions
	localparam int IRQ_RELEASED = 0;
	localparam int IRQ_RELOCKED = 1;
	localparam int IRQ_FAULT    = 2;
	localparam int IRQ_W        = 3;

	// ------------------------------------------------------------------
	// Time selection tables
	// ------------------------------------------------------------------
	localparam logic [4:0] UNL_SEG1_LAST = 5'h0a; // 1 s
	localparam logic [4:0] UNL_SEG2_LAST = 5'h1c; // 10 s
	localparam int unsigned UNL_STEP1_MS = 100;
	localparam int unsigned UNL_STEP2_MS = 500;
	localparam int unsigned UNL_STEP3_MS = 5000;
	localparam int unsigned UNL_BASE2_MS = 1000;
	localparam int unsigned UNL_BASE3_MS = 10000;
	localparam logic [4:0] FBK_SEG1_LAST = 5'h09; // 100 ms
	localparam logic [4:0] FBK_SEG2_LAST = 5'h1b; // 1 s
	localparam int unsigned FBK_STEP1_MS = 10;
	localparam int unsigned FBK_STEP2_MS = 50;
	localparam int unsigned FBK_STEP3_MS = 500;
	localparam int unsigned FBK_BASE2_MS = 100;
	localparam int unsigned FBK_BASE3_MS = 1000;

	// Lock cycle states, Gray coded along the normal path except the ST_WAIT_LOCK to ST_LOCKED step
	typedef enum logic [2:0] {
		ST_LOCKED    = 3'h0,
		ST_DELAY     = 3'h1,
		ST_WAIT_REL  = 3'h3,
		ST_RELEASED  = 3'h2,
		ST_WAIT_LOCK = 3'h6,
		ST_FAULT     = 3'h7
	} lock_st_e;

	// Unlock delay select index to tick count
	function automatic logic [CNT_W-1:0] unlock_ticks(input logic [4:0] i);
		int unsigned ms;
		if (i <= UNL_SEG1_LAST)
			ms = 32'(i) * UNL_STEP1_MS;
		else if (i <= UNL_SEG2_LAST)
			ms = UNL_BASE2_MS + 32'(i - UNL_SEG1_LAST) * UNL_STEP2_MS;
		else
			ms = UNL_BASE3_MS + 32'(i - UNL_SEG2_LAST) * UNL_STEP3_MS;
		return CNT_W'(ms / TICK_MS);
	endfunction

	// Feedback time select index to tick count
	function automatic logic [CNT_W-1:0] fbk_ticks(input logic [4:0] i);
		int unsigned ms;
		if (i <= FBK_SEG1_LAST)
			ms = 32'(i + 5'h01) * FBK_STEP1_MS;
		else if (i <= FBK_SEG2_LAST)
			ms = FBK_BASE2_MS + 32'(i - FBK_SEG1_LAST) * FBK_STEP2_MS;
		else
			ms = FBK_BASE3_MS + 32'(i - FBK_SEG2_LAST) * FBK_STEP3_MS;
		return CNT_W'(ms / TICK_MS);
	endfunction

endpackage

// ===== rtl/guard_lock_supervisor.sv
// Guard lock supervisor top level with AHB-Lite register slave
//
// Overview of operation
// - Unlock request drops status before drive changes
// - Drive releases only after unlock delay
// - Unlock delay selectable in three step ranges
// - Feedback time selectable in three step ranges
// - Feedback not following within time is fault
// - With gate, relock only once gate closed
// - Status true when locked and gate closed
// - Mandatory mode: no opening gives error
// - Mandatory mode: cycle needs opening then closing
// - Manual reset accepts one rising edge
// - Monitored reset needs rise then fall
// - Spring interlock: energised means released
// - No-gate option ignores the gate input, except in the mandatory-mode opening check
// - Enabled error output flags lock faults
// - Status held false during any fault
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps

module guard_lock_supervisor #(
	parameter int unsigned TICK_CYCLES = guard_lock_pkg::TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        unlock_req,
	input  wire logic        lock_fbk,
	input  wire logic        gate_closed,
	input  wire logic        fault_reset,
	output logic             lock_drive,
	output logic             guard_ok_status,
	output logic             error_out,
	output logic             irq
);

	// ------------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------------
	logic [1:0] rst_sync_q; // Release chain
	logic       rst_n_s;    // Synchronised reset

	// Assert at once, release after two edges
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n_s = rst_sync_q[1];

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	logic tick;      // Timing tick
	logic rst_accept; // Qualified fault reset

	guard_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk   (ref_clk),
		.rst_n (rst_n_s),
		.tick  (tick)
	);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		guard_lock_pkg::lock_st_e               st;      // Lock cycle
		logic [guard_lock_pkg::CNT_W-1:0]       cnt;     // Tick counter
		logic                                   opened;  // Gate seen open
		logic                                   fault;   // Latched fault
		logic                                   ok;      // Status output
		logic                                   drive;   // Actuator output
		logic                                   err;     // Error output
		logic                                   irq;     // Interrupt output
		logic [guard_lock_pkg::IRQ_W-1:0]       sts;     // Sticky events
		logic [guard_lock_pkg::IRQ_W-1:0]       mask;    // Event enables
		logic [guard_lock_pkg::CTRL_W-1:0]      ctrl;    // Options
		logic [4:0]                             unl_sel; // Delay select
		logic [4:0]                             fbk_sel; // Feedback select
		logic                                   wr_pend; // Write data phase
		logic [7:0]                             waddr;   // Write offset
		logic [31:0]                            rdata;   // Read data
		logic                                   ready;   // Bus ready
	} sup_s;

	sup_s q; // Registered state
	sup_s d; // Next state

	guard_reset_accept u_racc (
		.clk         (ref_clk),
		.rst_n       (rst_n_s),
		.fault_reset (fault_reset),
		.monitored   (q.ctrl[guard_lock_pkg::CTRL_MONITOR]),
		.accept      (rst_accept)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	logic gate_ok;  // Gate closed, or gate not fitted
	logic release_d; // Lock wanted released in next state
	localparam int IRQ_LEN = guard_lock_pkg::IRQ_W;
	logic addr_ph;  // Valid address phase this cycle
	logic [IRQ_LEN-1:0] set_ev; // Events raised this cycle

	always_comb begin
		d       = q;
		set_ev  = '0;
		d.ready = 1'b1;
		gate_ok = q.ctrl[guard_lock_pkg::CTRL_NO_GATE] || gate_closed;
		addr_ph = hsel && htrans[1] && hready;

		// Register writes land in the data phase
		d.wr_pend = addr_ph && hwrite;
		d.waddr   = haddr[7:0];
		if (q.wr_pend) begin
			case (q.waddr)
				guard_lock_pkg::OFF_CTRL:
					d.ctrl = hwdata[guard_lock_pkg::CTRL_W-1:0];
				guard_lock_pkg::OFF_UNL_SEL:
					d.unl_sel = hwdata[4:0];
				guard_lock_pkg::OFF_FBK_SEL:
					d.fbk_sel = hwdata[4:0];
				guard_lock_pkg::OFF_IRQ_MASK:
					d.mask = hwdata[IRQ_LEN-1:0];
				default: ;
			endcase
		end

		// Lock cycle; the timers advance only on the tick
		case (q.st)
			// Locked and supervised
			guard_lock_pkg::ST_LOCKED: begin
				if (unlock_req) begin
					d.st     = guard_lock_pkg::ST_DELAY;
					d.cnt    = guard_lock_pkg::unlock_ticks(q.unl_sel);
					d.opened = 1'b0;
				end else if (!gate_ok || !lock_fbk) begin
					d.st = guard_lock_pkg::ST_FAULT;
				end
			end
			// Waiting out the unlock delay
			guard_lock_pkg::ST_DELAY: begin
				if (!unlock_req) begin
					d.st = guard_lock_pkg::ST_LOCKED;
				end else if (q.cnt == '0) begin
					d.st  = guard_lock_pkg::ST_WAIT_REL;
					d.cnt = guard_lock_pkg::fbk_ticks(q.fbk_sel);
				end else if (tick) begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			// Released drive, feedback must follow
			guard_lock_pkg::ST_WAIT_REL: begin
				if (!lock_fbk) begin
					d.st = guard_lock_pkg::ST_RELEASED;
					set_ev[guard_lock_pkg::IRQ_RELEASED] = 1'b1;
				end else if (tick && q.cnt <= 1) begin
					d.st = guard_lock_pkg::ST_FAULT;
				end else if (tick) begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			// Unlocked; relock needs request gone and gate shut, or gate not fitted
			guard_lock_pkg::ST_RELEASED: begin
				if (!gate_closed)
					d.opened = 1'b1;
				if (!unlock_req && gate_ok) begin
					d.st  = guard_lock_pkg::ST_WAIT_LOCK;
					d.cnt = guard_lock_pkg::fbk_ticks(q.fbk_sel);
				end
			end
			// Drive back to locked, feedback must follow
			guard_lock_pkg::ST_WAIT_LOCK: begin
				if (lock_fbk) begin
					set_ev[guard_lock_pkg::IRQ_RELOCKED] = 1'b1;
					if (q.ctrl[guard_lock_pkg::CTRL_MAND] && !q.opened)
						d.st = guard_lock_pkg::ST_FAULT;
					else
						d.st = guard_lock_pkg::ST_LOCKED;
				end else if (tick && q.cnt <= 1) begin
					d.st = guard_lock_pkg::ST_FAULT;
				end else if (tick) begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			// Held safe until a qualified reset
			guard_lock_pkg::ST_FAULT: begin
				if (rst_accept) begin
					d.st    = guard_lock_pkg::ST_WAIT_LOCK;
					d.cnt   = guard_lock_pkg::fbk_ticks(q.fbk_sel);
					d.fault = 1'b0;
					d.err   = 1'b0;
					// A fault reset ends no unlock cycle: waive opening check
					d.opened = 1'b1;
				end
			end
			default: d.st = guard_lock_pkg::ST_FAULT;
		endcase

		// Fault entry latches the error flags
		if (d.st == guard_lock_pkg::ST_FAULT &&
		    q.st != guard_lock_pkg::ST_FAULT) begin
			d.fault = 1'b1;
			d.err   = q.ctrl[guard_lock_pkg::CTRL_ERR_EN];
			set_ev[guard_lock_pkg::IRQ_FAULT] = 1'b1;
		end

		// Outputs from the next state
		release_d = (d.st == guard_lock_pkg::ST_WAIT_REL) ||
		            (d.st == guard_lock_pkg::ST_RELEASED);
		// Spring lock is released by energising; power lock the reverse
		d.drive = q.ctrl[guard_lock_pkg::CTRL_SPRING] ? release_d
		                                              : !release_d;
		d.ok = (d.st == guard_lock_pkg::ST_LOCKED) && lock_fbk && gate_ok &&
		       !unlock_req && !d.fault;

		// Sticky events: a new event beats a same-cycle clear
		if (q.wr_pend && q.waddr == guard_lock_pkg::OFF_IRQ_STS)
			d.sts = q.sts & ~hwdata[IRQ_LEN-1:0];
		d.sts = d.sts | set_ev;
		d.irq = |(d.sts & d.mask);

		// Read data from the updated view so writes are seen at once
		d.rdata = 32'h0000_0000;
		if (addr_ph && !hwrite) begin
			case (haddr[7:0])
				guard_lock_pkg::OFF_CTRL:
					d.rdata[guard_lock_pkg::CTRL_W-1:0] = d.ctrl;
				guard_lock_pkg::OFF_UNL_SEL:  d.rdata[4:0] = d.unl_sel;
				guard_lock_pkg::OFF_FBK_SEL:  d.rdata[4:0] = d.fbk_sel;
				guard_lock_pkg::OFF_STATE:
					d.rdata[8:0] = {d.opened, d.fault, d.err, d.ok,
					                d.drive, 1'b0, d.st};
				guard_lock_pkg::OFF_IRQ_STS:  d.rdata[IRQ_LEN-1:0] = d.sts;
				guard_lock_pkg::OFF_IRQ_MASK: d.rdata[IRQ_LEN-1:0] = d.mask;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			q         <= '0;
			q.st      <= guard_lock_pkg::ST_LOCKED;
			q.ctrl    <= guard_lock_pkg::CTRL_RST;
			q.unl_sel <= guard_lock_pkg::UNL_SEL_RST;
			q.fbk_sel <= guard_lock_pkg::FBK_SEL_RST;
			q.sts     <= guard_lock_pkg::IRQ_RST;
			q.mask    <= guard_lock_pkg::IRQ_RST;
			q.drive   <= 1'b1;
			q.ready   <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register; hresp tied low
	assign hreadyout       = q.ready;
	assign hresp           = 1'b0;
	assign hrdata          = q.rdata;
	assign lock_drive      = q.drive;
	assign guard_ok_status = q.ok;
	assign error_out       = q.err;
	assign irq             = q.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_s);

	AST_OK_DROPS: assert property (
		unlock_req |=> !guard_ok_status)
		else $error("status stayed true under unlock request");
	AST_OK_BEFORE_DRIVE: assert property (
		$changed(lock_drive) && q.st == guard_lock_pkg::ST_WAIT_REL
		|-> !guard_ok_status && !$past(guard_ok_status))
		else $error("drive changed before status dropped");
	AST_DELAY_DONE: assert property (
		q.st == guard_lock_pkg::ST_DELAY &&
		d.st == guard_lock_pkg::ST_WAIT_REL |-> q.cnt == '0)
		else $error("drive released before unlock delay");
	AST_FBK_TIMEOUT: assert property (
		q.st == guard_lock_pkg::ST_WAIT_REL && tick && q.cnt == 1 && lock_fbk
		|=> q.st == guard_lock_pkg::ST_FAULT && q.fault)
		else $error("feedback timeout missed");
	AST_RELOCK_GATE: assert property (
		q.st == guard_lock_pkg::ST_RELEASED &&
		!q.ctrl[guard_lock_pkg::CTRL_NO_GATE] && !gate_closed
		|=> q.st != guard_lock_pkg::ST_WAIT_LOCK)
		else $error("relock with gate open");
	AST_OK_CAUSE: assert property (
		$rose(guard_ok_status) |-> $past(lock_fbk) &&
		($past(gate_closed) || q.ctrl[guard_lock_pkg::CTRL_NO_GATE]))
		else $error("status rose without lock and gate");
	AST_MAND_ERROR: assert property (
		q.st == guard_lock_pkg::ST_WAIT_LOCK && lock_fbk && !q.opened &&
		q.ctrl[guard_lock_pkg::CTRL_MAND] && q.ctrl[guard_lock_pkg::CTRL_ERR_EN]
		|=> error_out ##1 error_out)
		else $error("mandatory opening error not raised");
	AST_ERROR_OUT: assert property (
		$rose(q.fault) |-> error_out == q.ctrl[guard_lock_pkg::CTRL_ERR_EN])
		else $error("error output does not follow fault");
	AST_FAULT_NO_OK: assert property (
		q.fault |-> !guard_ok_status)
		else $error("status true during fault");
	AST_FAULT_HELD: assert property (
		q.fault && !rst_accept |=> q.fault)
		else $error("fault cleared without reset");

	COV_UNLOCK_CYCLE: cover property (
		q.st == guard_lock_pkg::ST_WAIT_LOCK ##1 q.st == guard_lock_pkg::ST_LOCKED);
	COV_FAULT: cover property ($rose(error_out));
	COV_RESET_OUT: cover property (q.fault ##1 !q.fault);

endmodule

// ===== rtl/guard_reset_accept.sv
// Fault reset input qualifier: manual or monitored acceptance
`timescale 1ns/1ps

module guard_reset_accept (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic fault_reset,
	input  wire logic monitored,
	output logic      accept
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic prev;   // Input one cycle ago
		logic armed;  // Rising edge seen, waiting for fall
		logic accept; // One-cycle acceptance pulse
	} racc_s;

	racc_s q; // Registered state
	racc_s d; // Next state

	// Edge tracking; monitored mode needs the full high pulse
	always_comb begin
		d        = q;
		d.prev   = fault_reset;
		d.accept = 1'b0;
		if (!monitored) begin
			d.armed  = 1'b0;
			d.accept = fault_reset && !q.prev;
		end else if (fault_reset && !q.prev) begin
			d.armed = 1'b1;
		end else if (!fault_reset && q.prev && q.armed) begin
			d.armed  = 1'b0;
			d.accept = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign accept = q.accept;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	AST_MANUAL_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
		!monitored && fault_reset && !q.prev |=> accept)
		else $error("manual reset edge not accepted");
	AST_MONITOR_FALL: assert property (@(posedge clk) disable iff (!rst_n)
		monitored && $rose(accept) |-> $past(q.prev) && !$past(fault_reset))
		else $error("monitored reset accepted without falling edge");

endmodule

// ===== rtl/guard_tick_gen.sv
// Periodic timing tick divider for the guard lock supervisor
`timescale 1ns/1ps

module guard_tick_gen #(
	parameter int unsigned TICK_CYCLES = guard_lock_pkg::TICK_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [guard_lock_pkg::TICK_W-1:0] cnt; // Cycles left to tick
		logic                               tick; // One-cycle pulse
	} tick_s;

	tick_s q; // Registered state
	tick_s d; // Next state

	// Count down and pulse once per period
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == '0) begin
			d.cnt  = guard_lock_pkg::TICK_W'(TICK_CYCLES - 1);
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;

endmodule

// ===== sim/guard_lock_model.sv
// Electromagnet and lock feedback contacts model
`timescale 1ns/1ps

module guard_lock_model #(
	parameter int FAST = 30,  // Prompt lock travel, cycles
	parameter int SLOW = 300  // Sluggish lock travel, cycles
) (
	input  wire logic ref_clk,
	input  wire logic lock_drive,
	input  wire logic spring,
	input  wire logic slow,
	output logic      lock_fbk
);
	logic tgt; // Level the contacts settle to
	int   cnt; // Cycles since the drive moved

	// Spring lock holds while de-energised, power lock the reverse
	assign tgt = spring ? ~lock_drive : lock_drive;

	// Contacts move only after the mechanical travel time, so a
	// drive that flips back early never shows on the feedback
	initial begin
		lock_fbk = 1'b1;
		cnt = 0;
	end
	always @(posedge ref_clk) begin
		if (tgt !== lock_fbk) begin
			cnt <= cnt + 1;
			if (cnt + 1 >= (slow ? SLOW : FAST))
				lock_fbk <= tgt;
		end else begin
			cnt <= 0;
		end
	end
endmodule

// ===== sim/guard_lock_supervisor_test.sv
// Self-checking bench for the guard lock supervisor
`timescale 1ns/1ps

module guard_lock_supervisor_test;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        ref_clk, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic        unlock_req, lock_fbk, gate_closed, fault_reset;
	logic        lock_drive, guard_ok_status, error_out, irq, slow, spring;
	int          mismatches, checks_done, n;

	// Short tick keeps timed paths to ten cycles per tick, one cycle per millisecond
	guard_lock_supervisor #(.TICK_CYCLES(10)) u_guard_lock_supervisor (
		.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.unlock_req(unlock_req), .lock_fbk(lock_fbk),
		.gate_closed(gate_closed), .fault_reset(fault_reset),
		.lock_drive(lock_drive), .guard_ok_status(guard_ok_status),
		.error_out(error_out), .irq(irq));

	// Lock type follows spring; power lock (energised locks) by default
	guard_lock_model u_guard_lock_model (.ref_clk(ref_clk),
		.lock_drive(lock_drive), .spring(spring), .slow(slow),
		.lock_fbk(lock_fbk));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask

	// One single word transfer; waits on hready, no fixed latency
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		q = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(q === e && hresp === 1'b0, "register read mismatch");
	endtask

	// Bounded wait for a level, sampled at the edge before it updates
	task automatic wait_sig(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	// Raise the request, return cycles until the drive lets go
	task automatic open_lock();
		@(posedge ref_clk);
		unlock_req <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(guard_ok_status === 1'b0 && lock_drive === !spring, "ok late");
		wait_sig(lock_drive, spring, 3000);
	endtask

	task automatic close_lock();
		unlock_req <= 1'b0;
		wait_sig(guard_ok_status, 1'b1, 400);
		chk(n < 400 && lock_drive === !spring, "no relock");
	endtask

	// Manual fault reset: a single rising edge
	task automatic clear_fault();
		fault_reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		fault_reset <= 1'b0;
		wait_sig(guard_ok_status, 1'b1, 400);
		chk(n < 400 && error_out === 1'b0, "reset refused");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd(guard_lock_pkg::OFF_CTRL, 32'h0000_0000);
		rd(guard_lock_pkg::OFF_UNL_SEL, 32'h0000_0005);
		rd(guard_lock_pkg::OFF_FBK_SEL, 32'h0000_0009);
		rd(guard_lock_pkg::OFF_IRQ_MASK, 32'h0000_0000);
		rd(guard_lock_pkg::OFF_IRQ_STS, 32'h0000_0000);
		rd(guard_lock_pkg::OFF_STATE, 32'h0000_0030);
		bus(1'b1, 8'h40, 32'hffff_ffff);
		rd(8'h40, 32'h0000_0000);
		bus(1'b1, guard_lock_pkg::OFF_IRQ_MASK, 32'hffff_ffff);
		rd(guard_lock_pkg::OFF_IRQ_MASK, 32'h0000_0007);
		bus(1'b1, guard_lock_pkg::OFF_IRQ_MASK, 32'h0000_0000);
	endtask

	// Gated cycle at the default half second delay, then interrupts
	task automatic t_cycle();
		open_lock();
		chk(n >= 485 && n <= 515, "unlock delay off");
		wait_sig(lock_fbk, 1'b0, 200);
		gate_closed <= 1'b0;
		unlock_req <= 1'b0;
		repeat (50) @(posedge ref_clk);
		chk(lock_drive === 1'b0, "relocked with gate open");
		gate_closed <= 1'b1;
		close_lock();
		chk(irq === 1'b0, "masked irq raised");
		rd(guard_lock_pkg::OFF_IRQ_STS, 32'h0000_0003);
		bus(1'b1, guard_lock_pkg::OFF_IRQ_MASK, 32'h0000_0007);
		repeat (2) @(posedge ref_clk);
		chk(irq === 1'b1, "irq not raised");
		bus(1'b1, guard_lock_pkg::OFF_IRQ_STS, 32'h0000_0003);
		repeat (2) @(posedge ref_clk);
		chk(irq === 1'b0, "irq not cleared");
	endtask

	// Low ends of the first two delay ranges
	task automatic t_delays();
		bus(1'b1, guard_lock_pkg::OFF_UNL_SEL, 32'h0000_0000);
		open_lock();
		chk(n <= 15, "zero delay slow");
		close_lock();
		bus(1'b1, guard_lock_pkg::OFF_UNL_SEL, 32'h0000_000b);
		open_lock();
		chk(n >= 1485 && n <= 1515, "1.5 s delay off");
		close_lock();
		bus(1'b1, guard_lock_pkg::OFF_UNL_SEL, 32'h0000_0000);
	endtask

	// Sluggish lock: 150 ms window trips, 1.5 s window does not
	task automatic t_feedback();
		bus(1'b1, guard_lock_pkg::OFF_CTRL, 32'h0000_0010);
		bus(1'b1, guard_lock_pkg::OFF_FBK_SEL, 32'h0000_000a);
		slow <= 1'b1;
		open_lock();
		wait_sig(error_out, 1'b1, 400);
		chk(n >= 135 && n <= 170, "feedback timeout off");
		chk(guard_ok_status === 1'b0, "ok during fault");
		unlock_req <= 1'b0;
		repeat (100) @(posedge ref_clk);
		chk(error_out === 1'b1, "error not held");
		rd(guard_lock_pkg::OFF_IRQ_STS, 32'h0000_0007);
		clear_fault();
		bus(1'b1, guard_lock_pkg::OFF_FBK_SEL, 32'h0000_001c);
		open_lock();
		wait_sig(lock_fbk, 1'b0, 400);
		chk(error_out === 1'b0, "long window tripped");
		close_lock();
		slow <= 1'b0;
	endtask

	// Gate opened while locked; monitored reset needs rise then fall
	task automatic t_monitored();
		bus(1'b1, guard_lock_pkg::OFF_CTRL, 32'h0000_0018);
		gate_closed <= 1'b0;
		wait_sig(error_out, 1'b1, 20);
		chk(n < 20 && guard_ok_status === 1'b0, "open gate ok");
		gate_closed <= 1'b1;
		fault_reset <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk(error_out === 1'b1, "rise alone accepted");
		fault_reset <= 1'b0;
		wait_sig(guard_ok_status, 1'b1, 400);
		chk(n < 400 && error_out === 1'b0, "monitored refused");
	endtask

	// Mandatory opening: missed opening errors, real one does not
	task automatic t_mandatory();
		bus(1'b1, guard_lock_pkg::OFF_CTRL, 32'h0000_0012);
		open_lock();
		wait_sig(lock_fbk, 1'b0, 200);
		unlock_req <= 1'b0;
		wait_sig(error_out, 1'b1, 400);
		chk(n < 400 && guard_ok_status === 1'b0, "no missed gate");
		clear_fault();
		open_lock();
		wait_sig(lock_fbk, 1'b0, 200);
		gate_closed <= 1'b0;
		repeat (20) @(posedge ref_clk);
		gate_closed <= 1'b1;
		repeat (5) @(posedge ref_clk);
		close_lock();
		chk(error_out === 1'b0, "opened gate flagged");
	endtask

	// Spring lock: energised drive releases, de-energised holds
	task automatic t_spring();
		bus(1'b1, guard_lock_pkg::OFF_CTRL, 32'h0000_0004);
		spring <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk(lock_drive === 1'b0 && guard_ok_status === 1'b1, "spring");
		open_lock();
		wait_sig(lock_fbk, 1'b0, 200);
		close_lock();
		bus(1'b1, guard_lock_pkg::OFF_CTRL, 32'h0000_0000);
		spring <= 1'b0;
	endtask

	// No gate fitted: an open gate line changes nothing
	task automatic t_no_gate();
		bus(1'b1, guard_lock_pkg::OFF_CTRL, 32'h0000_0011);
		gate_closed <= 1'b0;
		repeat (30) @(posedge ref_clk);
		chk(guard_ok_status === 1'b1 && error_out === 1'b0, "gate seen");
		open_lock();
		wait_sig(lock_fbk, 1'b0, 200);
		close_lock();
	endtask

	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		{mismatches, checks_done} = 0;
		{hsel, haddr, htrans, hwrite, hwdata} = 0;
		{unlock_req, fault_reset, slow, reset_n, spring} = 0;
		gate_closed = 1'b1;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs();
		t_cycle();
		t_delays();
		t_feedback();
		t_monitored();
		t_mandatory();
		t_spring();
		t_no_gate();
		complete_run();
	end

	// Whole run needs about 4k cycles; ten times that means a hang
	initial begin
		repeat (40000) @(posedge ref_clk);
		mismatches++;
		complete_run();
	end
endmodule
